//--- rtl/tmb_capture_regs.svh
// register indices, field positions and reset values of the capture timer
`ifndef TMB_CAPTURE_REGS_SVH
`define TMB_CAPTURE_REGS_SVH

`define TMB_IDX_CTRL_A          6'h00
`define TMB_IDX_CTRL_B          6'h01
`define TMB_IDX_EVENT_CTRL      6'h04
`define TMB_IDX_IRQ_MASK        6'h05
`define TMB_IDX_IRQ_FLAGS       6'h06
`define TMB_IDX_RUN_STATUS      6'h07
`define TMB_IDX_DEBUG_CTRL      6'h08
`define TMB_IDX_STAGING         6'h09
`define TMB_IDX_COUNT_LOW       6'h0a
`define TMB_IDX_COUNT_HIGH      6'h0b
`define TMB_IDX_CAPTURE_COMPARE_VALUE_LOW        6'h0c
`define TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH       6'h0d

`define TMB_ENABLE_BIT          0
`define TMB_MODE_MSB            2
`define TMB_MODE_LSB            0
`define TMB_EDGE_BIT            4
`define TMB_EVENT_EN_BIT        0
`define TMB_CAPTURE_FLAG_BIT    0
`define TMB_RUN_BIT             0
`define TMB_DEBUG_CONTINUE_BIT  0

`define TMB_BYTE_RESET          8'h00
`define TMB_WORD_RESET          16'h0000
`define TMB_MODE_RESET          3'h0

`endif

//--- rtl/tmb_capture_top.sv
// 16-bit capture/compare timer with APB register slave
//
// Overview of operation
// RULE1 - flag set on event; cleared by one-write or read
// RULE2 - compare modes flag when counter equals top
// RULE3 - frequency mode captures, restarts, flags
// RULE4 - capture mode loads counter and flags
// RULE5 - pulse mode: edge restarts, opposite edge captures
// RULE6 - combined mode stops on second edge, flags
// RULE7 - byte pwm: low compare byte is top
// RULE8 - run bit shows running, read-only
// RULE9 - break halt freezes unless debug continue
// RULE10 - shared resettable staging byte, read/write
// RULE11 - counter as two writable bytes
// RULE12 - bus write beats internal counter update
// RULE13 - capture register holds sampled counter
// RULE14 - compare register is top in compare modes
// RULE15 - byte pwm: low period, high duty
// RULE16 - three-bit mode field decodes eight modes
// RULE17 - interrupt only when enabled and flagged
// RULE18 - low read latches high; low write commits
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`include "tmb_capture_regs.svh"
module tmb_capture_top (
	input  wire logic        ref_clk_in,      // peripheral clock, 50 MHz
	input  wire logic        reset_n_in,      // async reset, active low
	input  wire logic        psel_in,         // apb select
	input  wire logic        penable_in,      // apb enable
	input  wire logic        pwrite_in,       // apb write
	input  wire logic [7:0]  paddr_in,        // apb byte address
	input  wire logic [31:0] pwdata_in,       // apb write data
	input  wire logic [3:0]  pstrb_in,        // apb byte strobes
	output logic      [31:0] prdata_out,      // apb read data
	output logic             pready_out,      // apb ready
	output logic             pslverr_out,     // apb error, unmapped
	input  wire logic        event_in,        // event system level
	input  wire logic        debug_halt_in,   // cpu stopped in break
	output logic             pwm_wave_out,    // byte pwm waveform
	output logic             irq_out          // interrupt, active high
);

	logic                      enable_q;
	tmb_pkg::tmb_mode_type     mode_q;
	logic                      edge_sel_q;
	logic                      event_en_q;
	logic                      irq_mask_q;
	logic                      flag_q;
	logic                      debug_continue_q;
	logic [7:0]                staging_q;
	logic [7:0]                snap_high_q;
	logic                      running_q;
	logic                      run_d;
	tmb_pkg::tmb_fpw_state_type fpw_q;
	tmb_pkg::tmb_fpw_state_type fpw_d;
	logic [31:0]               prdata_q;
	logic                      pwm_wave_q;

	logic [15:0] cnt;
	logic [15:0] capture_compare_value;
	logic [15:0] cnt_hw_val;
	logic        cnt_hw_we;
	logic        cnt_sw_we;
	logic [15:0] cnt_sw_val;
	logic        capture_compare_value_hw_we;
	logic        capture_compare_value_sw_we;
	logic [15:0] capture_compare_value_sw_val;
	logic        set_flag;
	logic        clr_flag;
	logic        halted;
	logic        step;
	logic        ev_rise;
	logic        ev_fall;
	logic        ev_sel;
	logic        ev_opp;
	logic        at_top;
	logic        at_top8;
	logic        capture_mode;

	logic [5:0]  idx;
	logic        setup_ph;
	logic        wr_acc;
	logic        rd_acc;
	logic        mapped;
	logic [7:0]  rd_byte;
	logic [7:0]  wbyte;

	assign idx      = paddr_in[7:2];
	assign setup_ph = psel_in & ~penable_in;
	assign wr_acc   = psel_in & penable_in & pwrite_in & mapped & pstrb_in[0];
	assign rd_acc   = psel_in & penable_in & ~pwrite_in & mapped;
	assign wbyte    = pwdata_in[7:0];

	// break halt freezes counting and drops events
	assign halted = debug_halt_in & ~debug_continue_q; // RULE9
	assign step   = enable_q & running_q & ~halted;
	assign ev_sel = event_en_q & enable_q & ~halted & (edge_sel_q ? ev_fall : ev_rise);
	assign ev_opp = event_en_q & enable_q & ~halted & (edge_sel_q ? ev_rise : ev_fall);

	assign at_top  = cnt == capture_compare_value; // RULE14
	assign at_top8 = cnt[7:0] == capture_compare_value[7:0]; // RULE15
	assign capture_mode = (mode_q == tmb_pkg::TMB_MODE_CAPTURE) || (mode_q == tmb_pkg::TMB_MODE_FREQ) ||
		(mode_q == tmb_pkg::TMB_MODE_PULSE) || (mode_q == tmb_pkg::TMB_MODE_FREQ_PULSE);

	tmb_edge_detect #(
		.RESET_LEVEL (1'b0)
	) u_edge (
		.ref_clk_in (ref_clk_in),
		.reset_n_in (reset_n_in),
		.level_in   (event_in),
		.rise_out   (ev_rise),
		.fall_out   (ev_fall)
	);

	tmb_wide_reg #(
		.WIDTH     (16),
		.RESET_VAL (`TMB_WORD_RESET)
	) u_count (
		.ref_clk_in (ref_clk_in),
		.reset_n_in (reset_n_in),
		.sw_we_in   (cnt_sw_we),
		.sw_val_in  (cnt_sw_val),
		.hw_we_in   (cnt_hw_we),
		.hw_val_in  (cnt_hw_val),
		.value_out  (cnt)
	);

	tmb_wide_reg #(
		.WIDTH     (16),
		.RESET_VAL (`TMB_WORD_RESET)
	) u_capture_compare_value (
		.ref_clk_in (ref_clk_in),
		.reset_n_in (reset_n_in),
		.sw_we_in   (capture_compare_value_sw_we),
		.sw_val_in  (capture_compare_value_sw_val),
		.hw_we_in   (capture_compare_value_hw_we),
		.hw_val_in  (cnt), // RULE13
		.value_out  (capture_compare_value)
	);

	// mode sequencing: counter next value, capture, flag set, run state
	always_comb
	begin
		cnt_hw_we  = 1'b0;
		cnt_hw_val = cnt + 16'h0001;
		capture_compare_value_hw_we = 1'b0;
		set_flag   = 1'b0;
		run_d      = running_q;
		fpw_d      = fpw_q;
		if (!enable_q)
		begin
			run_d = 1'b0;
			fpw_d = tmb_pkg::TMB_FP_WAIT;
		end
		else
		begin
			case (mode_q) // RULE16
				tmb_pkg::TMB_MODE_PERIODIC, tmb_pkg::TMB_MODE_TIMEOUT:
				begin
					if (mode_q == tmb_pkg::TMB_MODE_PERIODIC)
						run_d = 1'b1;
					else if (ev_sel)
						run_d = 1'b1;
					else if (ev_opp)
						run_d = 1'b0;
					cnt_hw_we = step;
					if (step && at_top)
					begin
						set_flag   = 1'b1; // RULE2
						cnt_hw_val = 16'h0000;
					end
				end
				tmb_pkg::TMB_MODE_CAPTURE:
				begin
					run_d     = 1'b1;
					cnt_hw_we = step;
					if (ev_sel)
					begin
						capture_compare_value_hw_we = 1'b1; // RULE4
						set_flag   = 1'b1;
					end
				end
				tmb_pkg::TMB_MODE_FREQ:
				begin
					run_d     = 1'b1;
					cnt_hw_we = step;
					if (ev_sel)
					begin
						capture_compare_value_hw_we = 1'b1; // RULE3
						set_flag   = 1'b1;
						cnt_hw_we  = 1'b1;
						cnt_hw_val = 16'h0000;
					end
				end
				tmb_pkg::TMB_MODE_PULSE:
				begin
					run_d     = 1'b1;
					cnt_hw_we = step;
					if (ev_sel)
					begin
						cnt_hw_we  = 1'b1; // RULE5
						cnt_hw_val = 16'h0000;
					end
					else if (ev_opp)
					begin
						capture_compare_value_hw_we = 1'b1; // RULE5
						set_flag   = 1'b1;
					end
				end
				tmb_pkg::TMB_MODE_FREQ_PULSE:
				begin
					cnt_hw_we = step;
					case (fpw_q)
						tmb_pkg::TMB_FP_WAIT:
							if (ev_sel)
							begin
								cnt_hw_we  = 1'b1;
								cnt_hw_val = 16'h0000;
								run_d      = 1'b1;
								fpw_d      = tmb_pkg::TMB_FP_HIGH;
							end
						tmb_pkg::TMB_FP_HIGH:
							if (ev_opp)
							begin
								capture_compare_value_hw_we = 1'b1;
								fpw_d      = tmb_pkg::TMB_FP_LOW;
							end
						tmb_pkg::TMB_FP_LOW:
							if (ev_sel)
							begin
								cnt_hw_we = 1'b0; // RULE6
								run_d     = 1'b0;
								set_flag  = 1'b1;
								fpw_d     = tmb_pkg::TMB_FP_DONE;
							end
						tmb_pkg::TMB_FP_DONE:
							// rearm only after software has taken the result
							if (!flag_q)
								fpw_d = tmb_pkg::TMB_FP_WAIT;
						default:
							fpw_d = tmb_pkg::TMB_FP_WAIT;
					endcase
				end
				tmb_pkg::TMB_MODE_SINGLE:
				begin
					if (event_en_q && !halted && (edge_sel_q ? (ev_rise | ev_fall) : ev_rise))
						run_d = 1'b1;
					cnt_hw_we = step;
					if (step && at_top)
					begin
						set_flag   = 1'b1; // RULE2
						run_d      = 1'b0;
						cnt_hw_val = 16'h0000;
					end
				end
				tmb_pkg::TMB_MODE_PWM8:
				begin
					run_d      = 1'b1;
					cnt_hw_we  = step;
					cnt_hw_val = {8'h00, cnt[7:0] + 8'h01};
					if (step && at_top8)
					begin
						set_flag   = 1'b1; // RULE7
						cnt_hw_val = 16'h0000;
					end
				end
				default:
					run_d = 1'b0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			running_q <= 1'b0;
			fpw_q     <= tmb_pkg::TMB_FP_WAIT;
		end
		else
		begin
			running_q <= run_d;
			fpw_q     <= fpw_d;
		end
	end

	// read of flags, one-write, or capture read clears; a new event wins
	assign clr_flag = (wr_acc && idx == `TMB_IDX_IRQ_FLAGS && wbyte[`TMB_CAPTURE_FLAG_BIT]) ||
		(rd_acc && idx == `TMB_IDX_IRQ_FLAGS) ||
		(rd_acc && idx == `TMB_IDX_CAPTURE_COMPARE_VALUE_LOW && capture_mode);

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			flag_q <= 1'b0;
		else if (set_flag)
			flag_q <= 1'b1; // RULE1
		else if (clr_flag)
			flag_q <= 1'b0; // RULE1
	end

	assign irq_out = flag_q & irq_mask_q; // RULE17

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			pwm_wave_q <= 1'b0;
		else
			pwm_wave_q <= (mode_q == tmb_pkg::TMB_MODE_PWM8) && enable_q && (cnt[7:0] < capture_compare_value[15:8]); // RULE15
	end

	assign pwm_wave_out = pwm_wave_q;

	// control registers
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			enable_q         <= 1'b0;
			mode_q           <= tmb_pkg::tmb_mode_type'(`TMB_MODE_RESET);
			edge_sel_q       <= 1'b0;
			event_en_q       <= 1'b0;
			irq_mask_q       <= 1'b0;
			debug_continue_q <= 1'b0;
		end
		else if (wr_acc)
		begin
			case (idx)
				`TMB_IDX_CTRL_A:
					enable_q <= wbyte[`TMB_ENABLE_BIT];
				`TMB_IDX_CTRL_B:
					mode_q <= tmb_pkg::tmb_mode_type'(wbyte[`TMB_MODE_MSB:`TMB_MODE_LSB]);
				`TMB_IDX_EVENT_CTRL:
				begin
					edge_sel_q <= wbyte[`TMB_EDGE_BIT];
					event_en_q <= wbyte[`TMB_EVENT_EN_BIT];
				end
				`TMB_IDX_IRQ_MASK:
					irq_mask_q <= wbyte[`TMB_CAPTURE_FLAG_BIT];
				`TMB_IDX_DEBUG_CTRL:
					debug_continue_q <= wbyte[`TMB_DEBUG_CONTINUE_BIT];
				default:
					irq_mask_q <= irq_mask_q;
			endcase
		end
	end

	// high bytes go through the shared staging byte, except the compare high byte in byte pwm, so a 16-bit pair moves at once
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			staging_q <= `TMB_BYTE_RESET; // RULE10
		else if (wr_acc && (idx == `TMB_IDX_STAGING || idx == `TMB_IDX_COUNT_HIGH ||
			(idx == `TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH && mode_q != tmb_pkg::TMB_MODE_PWM8)))
			staging_q <= wbyte; // RULE18
		else if (rd_acc && (idx == `TMB_IDX_COUNT_LOW || idx == `TMB_IDX_CAPTURE_COMPARE_VALUE_LOW))
			staging_q <= snap_high_q; // RULE18
	end

	assign cnt_sw_we  = wr_acc && idx == `TMB_IDX_COUNT_LOW; // RULE11
	assign cnt_sw_val = {staging_q, wbyte}; // RULE18
	assign capture_compare_value_sw_we = wr_acc && (idx == `TMB_IDX_CAPTURE_COMPARE_VALUE_LOW ||
		(idx == `TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH && mode_q == tmb_pkg::TMB_MODE_PWM8));
	// byte pwm keeps period and duty bytes apart, so no staging there
	assign capture_compare_value_sw_val = (mode_q == tmb_pkg::TMB_MODE_PWM8) ?
		((idx == `TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH) ? {wbyte, capture_compare_value[7:0]} : {capture_compare_value[15:8], wbyte}) : // RULE15
		{staging_q, wbyte};

	// read mux; the running bit has no write path at all
	always_comb
	begin
		mapped  = paddr_in[1:0] == 2'b00;
		rd_byte = 8'h00;
		case (idx)
			`TMB_IDX_CTRL_A:     rd_byte[`TMB_ENABLE_BIT] = enable_q;
			`TMB_IDX_CTRL_B:     rd_byte[`TMB_MODE_MSB:`TMB_MODE_LSB] = mode_q;
			`TMB_IDX_EVENT_CTRL:
			begin
				rd_byte[`TMB_EDGE_BIT]     = edge_sel_q;
				rd_byte[`TMB_EVENT_EN_BIT] = event_en_q;
			end
			`TMB_IDX_IRQ_MASK:   rd_byte[`TMB_CAPTURE_FLAG_BIT] = irq_mask_q;
			`TMB_IDX_IRQ_FLAGS:  rd_byte[`TMB_CAPTURE_FLAG_BIT] = flag_q;
			`TMB_IDX_RUN_STATUS: rd_byte[`TMB_RUN_BIT] = step; // RULE8
			`TMB_IDX_DEBUG_CTRL: rd_byte[`TMB_DEBUG_CONTINUE_BIT] = debug_continue_q;
			`TMB_IDX_STAGING:    rd_byte = staging_q;
			`TMB_IDX_COUNT_LOW:  rd_byte = cnt[7:0];
			`TMB_IDX_COUNT_HIGH: rd_byte = staging_q;
			`TMB_IDX_CAPTURE_COMPARE_VALUE_LOW:   rd_byte = capture_compare_value[7:0];
			`TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH:  rd_byte = (mode_q == tmb_pkg::TMB_MODE_PWM8) ? capture_compare_value[15:8] : staging_q;
			default:             mapped = 1'b0;
		endcase
	end

	// data and high-byte snapshot taken together in setup keep the pair coherent
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			prdata_q    <= 32'h0000_0000;
			snap_high_q <= `TMB_BYTE_RESET;
		end
		else if (setup_ph && !pwrite_in)
		begin
			prdata_q    <= {24'h00_0000, rd_byte};
			snap_high_q <= (idx == `TMB_IDX_CAPTURE_COMPARE_VALUE_LOW) ? capture_compare_value[15:8] : cnt[15:8];
		end
	end

	assign prdata_out  = prdata_q;
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~mapped;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	a_irq_gating: assert property (set_flag && irq_mask_q && !(wr_acc && idx == `TMB_IDX_IRQ_MASK) // RULE17
		|=> irq_out)
		else $error("enabled flag raised no irq");
	a_flag_set_wins: assert property (set_flag |=> flag_q) // RULE1
		else $error("flag lost on set");
	a_flag_clear: assert property (clr_flag && !set_flag |=> !flag_q) // RULE1
		else $error("flag not cleared");
	a_top_flag: assert property ((mode_q == tmb_pkg::TMB_MODE_PERIODIC) && step && at_top && !cnt_sw_we // RULE2
		|=> flag_q && cnt == 16'h0000)
		else $error("periodic top missed");
	a_freq_capture: assert property ((mode_q == tmb_pkg::TMB_MODE_FREQ) && ev_sel && !cnt_sw_we // RULE3
		&& !capture_compare_value_sw_we |=> capture_compare_value == $past(cnt) && cnt == 16'h0000 && flag_q)
		else $error("frequency capture wrong");
	a_event_capture: assert property ((mode_q == tmb_pkg::TMB_MODE_CAPTURE) && ev_sel && !capture_compare_value_sw_we // RULE4
		|=> capture_compare_value == $past(cnt) && flag_q)
		else $error("event capture wrong");
	// the step that moves zero to one is the one in the cycle after the restart
	a_pulse_restart: assert property ((mode_q == tmb_pkg::TMB_MODE_PULSE) && ev_sel && !cnt_sw_we // RULE5
		|=> cnt == 16'h0000 ##1 (cnt == 16'h0001 || !$past(step) || $past(cnt_sw_we) || $past(ev_sel)))
		else $error("pulse restart wrong");
	a_fpw_stop: assert property ((mode_q == tmb_pkg::TMB_MODE_FREQ_PULSE) && fpw_q == tmb_pkg::TMB_FP_LOW // RULE6
		&& ev_sel |=> !running_q && flag_q && fpw_q == tmb_pkg::TMB_FP_DONE)
		else $error("combined mode did not stop");
	a_pwm8_top: assert property ((mode_q == tmb_pkg::TMB_MODE_PWM8) && step && at_top8 && !cnt_sw_we // RULE7
		|=> flag_q && cnt == 16'h0000)
		else $error("byte pwm top missed");
	a_halt_freeze: assert property (halted && $past(halted) && !cnt_sw_we |=> cnt == $past(cnt)) // RULE9
		else $error("counter moved in break");
	a_write_wins: assert property (cnt_sw_we |=> cnt == $past(cnt_sw_val)) // RULE12
		else $error("counter write lost");
	a_low_read_latch: assert property (rd_acc && idx == `TMB_IDX_COUNT_LOW |=> staging_q == $past(snap_high_q)) // RULE18
		else $error("high byte not staged");

	c_freq_capture: cover property ((mode_q == tmb_pkg::TMB_MODE_FREQ) && ev_sel);
	c_fpw_done: cover property (fpw_q == tmb_pkg::TMB_FP_DONE);
	c_irq_raised: cover property (irq_out);
	c_break_halt: cover property (halted && enable_q);

endmodule // tmb_capture_top

//--- rtl/tmb_edge_detect.sv
// edge detector for the event input level
`timescale 1ns/1ns
module tmb_edge_detect #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input  wire logic ref_clk_in,   // peripheral clock
	input  wire logic reset_n_in,   // async reset, active low
	input  wire logic level_in,     // event level, same clock domain
	output logic      rise_out,     // one-cycle pulse on rising edge
	output logic      fall_out      // one-cycle pulse on falling edge
);

	logic prev_q;

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			prev_q <= RESET_LEVEL;
		else
			prev_q <= level_in;
	end

	assign rise_out = level_in & ~prev_q;
	assign fall_out = ~level_in & prev_q;

endmodule // tmb_edge_detect

//--- rtl/tmb_pkg.sv
// types shared by the capture timer files
package tmb_pkg;

	typedef enum logic [2:0]
	{
		TMB_MODE_PERIODIC   = 3'h0,
		TMB_MODE_TIMEOUT    = 3'h1,
		TMB_MODE_CAPTURE    = 3'h2,
		TMB_MODE_FREQ       = 3'h3,
		TMB_MODE_PULSE      = 3'h4,
		TMB_MODE_FREQ_PULSE = 3'h5,
		TMB_MODE_SINGLE     = 3'h6,
		TMB_MODE_PWM8       = 3'h7
	} tmb_mode_type;

	typedef enum logic [3:0]
	{
		TMB_FP_WAIT = 4'h1,
		TMB_FP_HIGH = 4'h2,
		TMB_FP_LOW  = 4'h4,
		TMB_FP_DONE = 4'h8
	} tmb_fpw_state_type;

endpackage

//--- rtl/tmb_wide_reg.sv
// 16-bit value register where a software write overrides a hardware load
`timescale 1ns/1ns
module tmb_wide_reg #(
	parameter int                 WIDTH     = 16,
	parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
	input  wire logic             ref_clk_in,   // peripheral clock
	input  wire logic             reset_n_in,   // async reset, active low
	input  wire logic             sw_we_in,     // software commit
	input  wire logic [WIDTH-1:0] sw_val_in,    // software value
	input  wire logic             hw_we_in,     // internal update
	input  wire logic [WIDTH-1:0] hw_val_in,    // internal value
	output logic      [WIDTH-1:0] value_out     // stored value
);

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			value_out <= RESET_VAL;
		else if (sw_we_in)
			value_out <= sw_val_in; // RULE12
		else if (hw_we_in)
			value_out <= hw_val_in;
	end

endmodule // tmb_wide_reg

//--- testbench/tb_timer_b_capture_regs.sv
// self-checking bench of the capture timer and its register slave
`timescale 1ns/1ns
`include "tmb_capture_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb_timer_b_capture_regs;
	logic        clk     = 1'b0;
	logic        rst_n   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        evt_lvl = 1'b0;
	logic        evt;
	logic        halt    = 1'b0;
	logic        pwm;
	logic        irq;
	int          n_mismatch = 0;
	int          checked    = 0;

	always #10 clk = ~clk;

	tmb_event_model tmb_event_model_inst (
		.ref_clk_in (clk),
		.reset_n_in (rst_n),
		.level_in   (evt_lvl),
		.event_out  (evt)
	);

	tmb_capture_top tmb_capture_top_inst (
		.ref_clk_in    (clk),
		.reset_n_in    (rst_n),
		.psel_in       (psel),
		.penable_in    (penable),
		.pwrite_in     (pwrite),
		.paddr_in      (paddr),
		.pwdata_in     (pwdata),
		.pstrb_in      (4'hf),
		.prdata_out    (prdata),
		.pready_out    (pready),
		.pslverr_out   (pslverr),
		.event_in      (evt),
		.debug_halt_in (halt),
		.pwm_wave_out  (pwm),
		.irq_out       (irq)
	);

	task automatic final_report();
		if (n_mismatch == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// request held until pready is seen high with psel and penable
	task automatic xf(input logic [5:0] i, input logic w, input logic [7:0] d, output logic [7:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// no fixed wait count: only the watchdog ends a hung access
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		logic [7:0] q;
		logic       e;
		xf(i, 1'b1, d, q, e);
	endtask

	task automatic rd(input logic [5:0] i, output logic [7:0] q);
		logic e;
		xf(i, 1'b0, 8'h00, q, e);
	endtask

	// low byte first on reads, high byte first on writes
	task automatic rd16(input logic [5:0] lo, input logic [5:0] hi, output logic [15:0] v);
		rd(lo, v[7:0]);
		rd(hi, v[15:8]);
	endtask

	task automatic wr16(input logic [5:0] lo, input logic [5:0] hi, input logic [15:0] v);
		wr(hi, v[15:8]);
		wr(lo, v[7:0]);
	endtask

	task automatic ev(input logic l);
		@(posedge clk);
		evt_lvl <= l;
		repeat (4) @(posedge clk);
	endtask

	task automatic chk_irq(input logic exp);
		#1;
		`CHK(irq, exp)
	endtask

	task automatic wait_irq(input int bound);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < bound)
		begin
			@(posedge clk);
			n++;
		end
		`CHK(irq, 1'b1)
	endtask

	// stop the counter and empty the flag before a new mode
	task automatic idle(input logic [2:0] mode);
		logic [7:0] q;
		wr(`TMB_IDX_CTRL_A, 8'h00);
		rd(`TMB_IDX_IRQ_FLAGS, q);
		wr(`TMB_IDX_CTRL_B, {5'h00, mode});
	endtask

	task automatic t_reset();
		logic [7:0]  q;
		logic [15:0] v;
		logic        e;
		rd(`TMB_IDX_RUN_STATUS, q);
		`CHK(q, 8'h00)
		rd(`TMB_IDX_DEBUG_CTRL, q);
		`CHK(q, 8'h00)
		rd(`TMB_IDX_STAGING, q);
		`CHK(q, 8'h00)
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, v);
		`CHK(v, 16'h0000)
		rd16(`TMB_IDX_CAPTURE_COMPARE_VALUE_LOW, `TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH, v);
		`CHK(v, 16'h0000)
		wr(`TMB_IDX_RUN_STATUS, 8'hff);
		rd(`TMB_IDX_RUN_STATUS, q);
		`CHK(q, 8'h00)
		wr(`TMB_IDX_STAGING, 8'ha5);
		rd(`TMB_IDX_STAGING, q);
		`CHK(q, 8'ha5)
		xf(6'h02, 1'b0, 8'h00, q, e);
		`CHK(e, 1'b1)
		chk_irq(1'b0);
	endtask

	task automatic t_periodic();
		logic [7:0]  q;
		logic [15:0] v;
		idle(3'h0);
		wr16(`TMB_IDX_CAPTURE_COMPARE_VALUE_LOW, `TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH, 16'h0005);
		wr(`TMB_IDX_IRQ_MASK, 8'h01);
		wr(`TMB_IDX_CTRL_A, 8'h01);
		rd(`TMB_IDX_RUN_STATUS, q);
		`CHK(q, 8'h01)
		wait_irq(20);
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, v);
		`CHK(v <= 16'h0005, 1'b1)
		wr(`TMB_IDX_CTRL_A, 8'h00);
		wr(`TMB_IDX_IRQ_FLAGS, 8'h01);
		chk_irq(1'b0);
		wr(`TMB_IDX_IRQ_MASK, 8'h00);
		wr(`TMB_IDX_CTRL_A, 8'h01);
		repeat (20) @(posedge clk);
		chk_irq(1'b0);
		wr(`TMB_IDX_IRQ_MASK, 8'h01);
		chk_irq(1'b1);
	endtask

	task automatic t_capture();
		logic [15:0] v;
		logic [7:0]  q;
		idle(3'h2);
		wr(`TMB_IDX_EVENT_CTRL, 8'h01);
		wr(`TMB_IDX_CTRL_A, 8'h01);
		wr16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, 16'h1230);
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, v);
		`CHK(v >= 16'h1230 && v < 16'h1240, 1'b1)
		ev(1'b1);
		chk_irq(1'b1);
		rd16(`TMB_IDX_CAPTURE_COMPARE_VALUE_LOW, `TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH, v);
		`CHK(v >= 16'h1230 && v < 16'h1260, 1'b1)
		chk_irq(1'b0);
		ev(1'b0);
		chk_irq(1'b0);
		// falling edge selected: rise ignored, fall captures
		wr(`TMB_IDX_EVENT_CTRL, 8'h11);
		ev(1'b1);
		chk_irq(1'b0);
		ev(1'b0);
		chk_irq(1'b1);
		wr(`TMB_IDX_EVENT_CTRL, 8'h01);
		rd(`TMB_IDX_IRQ_FLAGS, q);
		chk_irq(1'b0);
	endtask

	task automatic t_freq_pulse();
		logic [15:0] v;
		logic [15:0] c;
		wr(`TMB_IDX_CTRL_B, 8'h03);
		ev(1'b1);
		chk_irq(1'b1);
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, c);
		`CHK(c < 16'h0020, 1'b1)
		rd16(`TMB_IDX_CAPTURE_COMPARE_VALUE_LOW, `TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH, v);
		`CHK(v > 16'h1230, 1'b1)
		ev(1'b0);
		wr(`TMB_IDX_CTRL_B, 8'h04);
		ev(1'b1);
		repeat (10) @(posedge clk);
		ev(1'b0);
		chk_irq(1'b1);
		rd16(`TMB_IDX_CAPTURE_COMPARE_VALUE_LOW, `TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH, v);
		`CHK(v >= 16'h000a && v < 16'h001e, 1'b1)
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, c);
		`CHK(c > v, 1'b1)
	endtask

	task automatic t_fpw();
		logic [15:0] a;
		logic [15:0] b;
		logic [7:0]  q;
		wr(`TMB_IDX_CTRL_B, 8'h05);
		ev(1'b1);
		ev(1'b0);
		chk_irq(1'b0);
		ev(1'b1);
		chk_irq(1'b1);
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, a);
		repeat (5) @(posedge clk);
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, b);
		`CHK(b, a)
		rd(`TMB_IDX_RUN_STATUS, q);
		`CHK(q, 8'h00)
		ev(1'b0);
	endtask

	task automatic t_debug();
		logic [15:0] a;
		logic [15:0] b;
		idle(3'h2);
		wr(`TMB_IDX_CTRL_A, 8'h01);
		@(posedge clk);
		halt <= 1'b1;
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, a);
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, b);
		`CHK(b, a)
		ev(1'b1);
		chk_irq(1'b0);
		wr(`TMB_IDX_DEBUG_CTRL, 8'h01);
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, a);
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, b);
		`CHK(b != a, 1'b1)
		halt <= 1'b0;
		ev(1'b0);
		wr(`TMB_IDX_DEBUG_CTRL, 8'h00);
	endtask

	task automatic t_top_modes();
		logic [7:0] q;
		idle(3'h6);
		wr16(`TMB_IDX_CAPTURE_COMPARE_VALUE_LOW, `TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH, 16'h0008);
		wr16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, 16'h0000);
		wr(`TMB_IDX_CTRL_A, 8'h01);
		ev(1'b1);
		wait_irq(30);
		repeat (3) @(posedge clk);
		rd(`TMB_IDX_RUN_STATUS, q);
		`CHK(q, 8'h00)
		idle(3'h1);
		wr16(`TMB_IDX_CAPTURE_COMPARE_VALUE_LOW, `TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH, 16'h0100);
		wr(`TMB_IDX_CTRL_A, 8'h01);
		ev(1'b0);
		ev(1'b1);
		rd(`TMB_IDX_RUN_STATUS, q);
		`CHK(q, 8'h01)
		ev(1'b0);
		rd(`TMB_IDX_RUN_STATUS, q);
		`CHK(q, 8'h00)
	endtask

	task automatic t_pwm();
		logic [7:0]  q;
		logic [15:0] v;
		int          h;
		h = 0;
		idle(3'h7);
		// start from zero so the low byte never has to wrap past the period
		wr16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, 16'h0000);
		wr(`TMB_IDX_CAPTURE_COMPARE_VALUE_LOW, 8'h09);
		wr(`TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH, 8'h04);
		rd(`TMB_IDX_CAPTURE_COMPARE_VALUE_HIGH, q);
		`CHK(q, 8'h04)
		wr(`TMB_IDX_CTRL_A, 8'h01);
		wait_irq(30);
		rd16(`TMB_IDX_COUNT_LOW, `TMB_IDX_COUNT_HIGH, v);
		`CHK(v <= 16'h0009, 1'b1)
		// two whole periods of ten counts, four high in each
		repeat (20)
		begin
			@(posedge clk);
			h += (pwm === 1'b1) ? 1 : 0;
		end
		`CHK(h, 8)
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_periodic();
		t_capture();
		t_freq_pulse();
		t_fpw();
		t_debug();
		t_top_modes();
		t_pwm();
		final_report();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
endmodule // tb_timer_b_capture_regs

//--- testbench/tmb_event_model.sv
// event system model: drives the event level from a registered request
`timescale 1ns/1ns
module tmb_event_model (
	input  wire logic ref_clk_in,   // peripheral clock
	input  wire logic reset_n_in,   // async reset, active low
	input  wire logic level_in,     // requested event level
	output logic      event_out     // event level toward the timer
);
	// level changes only right after a clock edge, as the event system does
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			event_out <= 1'b0;
		else
			event_out <= level_in;
	end
endmodule // tmb_event_model
